// >>> test/pld_led_props.sv
`timescale 1ns/1ps
`include "pld_led_regs.vh"
module pld_led_props (
	input wire        ref_clk_i,
	input wire        rst_n_i,
	input wire        spi_mode_i,
	input wire        led_clk_src_i,
	input wire [15:0] led_mode_i,
	input wire [63:0] led_duty_i,
	input wire [3:0]  led_c_n_o,
	input wire [3:0]  led_c_oe_o,
	input wire [3:0]  led_d_n_o,
	input wire [3:0]  led_d_oe_o,
	input wire        led_sync_pin_oe_o
);
	property p_float;
		@(posedge ref_clk_i) !rst_n_i |=> (led_c_oe_o | led_d_oe_o) == 4'h0;
	endproperty
	a_float: assert property (p_float) else $error("LED driven in reset");
	property p_dark;
		@(posedge ref_clk_i) !rst_n_i |=> (led_c_n_o & led_d_n_o) == 4'hf;
	endproperty
	a_dark: assert property (p_dark) else $error("LED low in reset");
	property p_drive;
		@(posedge ref_clk_i) disable iff (!rst_n_i) 1'b1 |=> (led_c_oe_o & led_d_oe_o) == 4'hf;
	endproperty
	a_drive: assert property (p_drive) else $error("LED not driven");
	property p_on;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
			(led_mode_i[1:0] == `PLD_MODE_ON) [*3] |-> !led_c_n_o[0];
	endproperty
	a_on: assert property (p_on) else $error("LED on not low");
	property p_off;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
			(led_mode_i[1:0] == `PLD_MODE_OFF) [*3] |-> led_c_n_o[0];
	endproperty
	a_off: assert property (p_off) else $error("LED off not high");
	property p_zero;
		@(posedge ref_clk_i) disable iff (!rst_n_i)
			(led_mode_i[3] && led_duty_i[15:8] == 8'h00) [*3] |-> led_d_n_o[0];
	endproperty
	a_zero: assert property (p_zero) else $error("Duty zero lit");
	property p_sdrv;
		@(posedge ref_clk_i) disable iff (!rst_n_i) (spi_mode_i && !led_clk_src_i) [*2]
			|-> led_sync_pin_oe_o;
	endproperty
	a_sdrv: assert property (p_sdrv) else $error("Sync pin not driven");
	property p_srx;
		@(posedge ref_clk_i) disable iff (!rst_n_i) (spi_mode_i && led_clk_src_i) [*2]
			|-> !led_sync_pin_oe_o;
	endproperty
	a_srx: assert property (p_srx) else $error("Sync pin driven");
endmodule
bind pld_led_top pld_led_props u_props (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
	.spi_mode_i(spi_mode_i), .led_clk_src_i(led_clk_src_i), .led_mode_i(led_mode_i),
	.led_duty_i(led_duty_i), .led_c_n_o(led_c_n_o), .led_c_oe_o(led_c_oe_o),
	.led_d_n_o(led_d_n_o), .led_d_oe_o(led_d_oe_o), .led_sync_pin_oe_o(led_sync_pin_oe_o));

// >>> test/pld_peer.sv
`timescale 1ns/1ps
module pld_peer (
	input  wire ref_clk_i,
	input  wire en_i,
	output reg  led_clk_o
);
	reg [5:0] cnt_reg = 6'h00;
	initial led_clk_o = 1'b0;
	// One LED tick every 64 cycles; low when not forwarding
	always @(posedge ref_clk_i) begin
		cnt_reg <= en_i ? cnt_reg + 6'h01 : 6'h00;
		led_clk_o <= en_i & cnt_reg[5];
	end
endmodule

// >>> test/tb_top.sv
`timescale 1ns/1ps
`include "pld_led_regs.vh"
module tb_top;
	reg        ref_clk_i = 1'b0;
	reg        rst_n_i = 1'b0;
	reg        spi_mode_i = 1'b1;
	reg        src = 1'b0;
	reg        pen = 1'b0;
	reg [15:0] mode = 16'h0000;
	reg [7:0]  duty = 8'h00;
	reg [7:0]  toff = 8'h02;
	wire [3:0] c_n, c_oe, d_n, d_oe;
	wire       s_o, s_oe, pclk, c_out;
	// Sync pin has a pull-down when nobody drives it
	wire       sync_w = s_oe ? s_o : (pen & spi_mode_i & pclk);
	integer    n_fail = 0, num_checks = 0, lit, i, co;
	always #4 ref_clk_i = ~ref_clk_i;
	pld_led_top dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .spi_mode_i(spi_mode_i),
		.led_clk_src_i(src), .blink_sync_i(1'b0), .led_mode_i(mode),
		.led_duty_i({8{duty}}), .led_on_time_i(64'h0), .led_off_time_i({8{toff}}),
		.led_c_n_o(c_n), .led_c_oe_o(c_oe), .led_d_n_o(d_n), .led_d_oe_o(d_oe),
		.led_sync_pin_i(sync_w), .led_sync_pin_o(s_o), .led_sync_pin_oe_o(s_oe),
		.chain_in_pin_i(pen & pclk), .chain_out_pin_o(c_out));
	pld_peer peer (.ref_clk_i(ref_clk_i), .en_i(pen), .led_clk_o(pclk));
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				n_fail = n_fail + 1;
				$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task end_sim;
		begin
			if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
			else $display("*** FAIL ***");
			$finish;
		end
	endtask
	// Counts lit cycles of one C and one D output after settling
	task run(input [1:0] m, input [7:0] d, input integer n);
		begin
			@(posedge ref_clk_i);
			mode <= {8{m}};
			duty <= d;
			repeat (200) @(posedge ref_clk_i);
			lit = 0;
			co = 0;
			repeat (n) begin
				@(negedge ref_clk_i);
				lit = lit + !c_n[0] + !d_n[3];
				co = co + c_out;
			end
		end
	endtask
	initial begin
		repeat (16) @(posedge ref_clk_i);
		chk({c_oe, d_oe, c_n, d_n}, 16'h00ff);
		rst_n_i <= 1'b1;
		repeat (2) @(negedge ref_clk_i);
		chk({c_oe, d_oe, c_n, d_n}, 16'hffff);
		run(`PLD_MODE_ON, 8'h00, 256);
		chk(lit, 512);
		// Internal LED clock is high for the first half tick, forwarded on both pins
		chk({s_oe, s_o, c_out}, 3'h7);
		run(`PLD_MODE_OFF, 8'hff, 256);
		chk(lit, 0);
		run(`PLD_MODE_DIM, 8'h00, 256);
		chk(lit, 0);
		run(`PLD_MODE_DIM, 8'h80, 256);
		chk(lit, 256);
		run(`PLD_MODE_DIM, 8'hff, 256);
		chk(lit, 510);
		run(`PLD_MODE_BLINK, 8'h00, 256);
		chk(lit, 0);
		src <= 1'b1;
		pen <= 1'b1;
		for (i = 0; i < 2; i = i + 1) begin
			spi_mode_i <= ~i[0];
			// On time 0 counts as one tick, off is two: lit one third
			run(`PLD_MODE_BLINK, 8'hff, 768);
			chk(lit >= 506 && lit <= 512, 1);
			// Received clock is repeated on chain out: high half of each 64-cycle period
			chk(co, 384);
			chk(s_oe, 0);
		end
		end_sim;
	end
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		n_fail = n_fail + 1;
		end_sim;
	end
endmodule

// >>> verilog/pld_led_chan.v
`timescale 1ns/1ps
`include "pld_led_regs.vh"

module pld_led_chan (
	// Clock and reset
	input  wire       ref_clk_i,
	input  wire       rst_n_i,
	// Shared timing
	input  wire       tick_i,
	input  wire       blink_restart_i,
	input  wire [7:0] pwm_cnt_i,
	// Configuration
	input  wire [1:0] mode_i,
	input  wire [7:0] duty_i,
	input  wire [7:0] on_time_i,
	input  wire [7:0] off_time_i,
	// LED drive, high means lit
	output reg        lit_o
);

	reg  [7:0] phase_cnt_reg;
	reg        phase_on_reg;
	wire [7:0] on_len;
	wire [7:0] off_len;
	wire [7:0] cur_len;
	wire       pwm_on;

	assign on_len  = (on_time_i == 8'h00) ? 8'h01 : on_time_i; // R13
	assign off_len = (off_time_i == 8'h00) ? 8'h01 : off_time_i; // R13
	assign cur_len = phase_on_reg ? on_len : off_len;
	// Duty 0 never lights; 255 lights 255 of 256 steps
	assign pwm_on  = (pwm_cnt_i < duty_i); // R8

	always @(posedge ref_clk_i) begin
		if (!rst_n_i || blink_restart_i) begin
			phase_cnt_reg <= 8'h00;
			phase_on_reg  <= 1'b1;
		end else if (tick_i) begin
			if (phase_cnt_reg + 8'h01 >= cur_len) begin // R7
				phase_cnt_reg <= 8'h00;
				phase_on_reg  <= ~phase_on_reg; // R6
			end else begin
				phase_cnt_reg <= phase_cnt_reg + 8'h01;
			end
		end
	end

	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			lit_o <= 1'b0;
		end else begin
			case (mode_i) // R4
				`PLD_MODE_OFF:   lit_o <= 1'b0;
				`PLD_MODE_ON:    lit_o <= 1'b1;
				`PLD_MODE_DIM:   lit_o <= pwm_on; // R5
				`PLD_MODE_BLINK: lit_o <= phase_on_reg & pwm_on; // R6
				default:         lit_o <= 1'b0;
			endcase
		end
	end

endmodule

// >>> verilog/pld_led_regs.vh
`ifndef PLD_LED_REGS_VH
`define PLD_LED_REGS_VH

// LED mode encodings
`define PLD_MODE_OFF        2'h0
`define PLD_MODE_ON         2'h1
`define PLD_MODE_DIM        2'h2
`define PLD_MODE_BLINK      2'h3

// Clock and tick timing
`define PLD_CLK_PERIOD_PS   8000
`define PLD_TICK_TIME_US    2500
// Scaled down to ns first: the product in ps overflows 32-bit integer arithmetic
`define PLD_TICK_CYCLES     ((`PLD_TICK_TIME_US * 1000) / (`PLD_CLK_PERIOD_PS / 1000))

// Reset values
`define PLD_DUTY_RST        8'h00
`define PLD_MODE_RST        2'h0
`define PLD_TIME_RST        8'h00

// LED clock source select
`define PLD_SRC_INTERNAL    1'b0
`define PLD_SRC_EXTERNAL    1'b1

`endif

// >>> verilog/pld_led_top.v
// Operation
// R1 - An LED is lit by driving its output low and dark by driving it high.
// R2 - Both LED output sets float while the device is held in reset.
// R3 - After reset the LED outputs are driven and default high, LEDs off.
// R4 - Each LED of each port is set to on, off, dimmed or blinking.
// R5 - Dimmed mode keeps the LED on with brightness from the duty value.
// R6 - Blinking alternates on and off phases, the on phase dimmed by duty.
// R7 - Blink on and off times are set separately from 2.5 ms to 637.5 ms.
// R8 - Duty has 256 levels, 0 fully dark and 255 brightest.
// R9 - Duty resets to 0 so dimmed and blinking LEDs stay dark until set.
// R10 - Blink phases of all four ports follow one common LED timing clock.
// R11 - In SPI mode one device drives its LED clock on the sync pin, others take it.
// R12 - In I2C mode the first chain device drives chain out, later ones take chain in.
// R13 - Each phase is an 8-bit count of 2.5 ms ticks, zero taken as one tick.
// R14 - The dimming counter repeats fast enough to show no flicker.
`timescale 1ns/1ps
`include "pld_led_regs.vh"

module pld_led_top (
	// Clock and reset
	input  wire        ref_clk_i,
	input  wire        rst_n_i,
	// Host interface type: 1 selects SPI sync pin, 0 selects I2C chain
	input  wire        spi_mode_i,
	// LED clock source: 1 takes an external LED clock
	input  wire        led_clk_src_i,
	// Restart all blink phases together
	input  wire        blink_sync_i,
	// Per-LED config, index = port*2 + led (led 0 drives C, led 1 drives D)
	input  wire [15:0] led_mode_i,
	input  wire [63:0] led_duty_i,
	input  wire [63:0] led_on_time_i,
	input  wire [63:0] led_off_time_i,
	// LED outputs, active low
	output reg  [3:0]  led_c_n_o,
	output reg  [3:0]  led_c_oe_o,
	output reg  [3:0]  led_d_n_o,
	output reg  [3:0]  led_d_oe_o,
	// SPI-mode sync pin
	input  wire        led_sync_pin_i,
	output reg         led_sync_pin_o,
	output reg         led_sync_pin_oe_o,
	// I2C-mode daisy chain
	input  wire        chain_in_pin_i,
	output reg         chain_out_pin_o
);

	localparam [31:0] TICK_CYC  = `PLD_TICK_CYCLES;
	localparam [31:0] HALF_CYC  = TICK_CYC / 2;

	reg  [31:0] div_reg;
	reg         int_clk_reg;
	reg         ext_d1_reg;
	reg         ext_d2_reg;
	reg         ext_d3_reg;
	reg  [7:0]  pwm_cnt_reg;
	reg         sync_d_reg;
	wire        ext_in;
	wire        ext_rise;
	wire        int_tick;
	wire        tick;
	wire        restart;
	wire [7:0]  lit;

	// Internal LED clock: one period per 2.5 ms tick
	assign int_tick = (div_reg == TICK_CYC - 32'h1);

	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			div_reg     <= 32'h0;
			int_clk_reg <= 1'b0;
		end else begin
			if (int_tick)
				div_reg <= 32'h0;
			else
				div_reg <= div_reg + 32'h1;
			int_clk_reg <= (div_reg < HALF_CYC);
		end
	end

	// External LED clock arrives on sync pin or chain in, synchronised first
	assign ext_in = spi_mode_i ? led_sync_pin_i : chain_in_pin_i; // R11 R12

	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ext_d1_reg <= 1'b0;
			ext_d2_reg <= 1'b0;
			ext_d3_reg <= 1'b0;
		end else begin
			ext_d1_reg <= ext_in;
			ext_d2_reg <= ext_d1_reg;
			ext_d3_reg <= ext_d2_reg;
		end
	end

	assign ext_rise = ext_d2_reg & ~ext_d3_reg;
	// One tick source for all ports keeps their blinking aligned
	assign tick     = (led_clk_src_i == `PLD_SRC_EXTERNAL) ? ext_rise : int_tick; // R10

	// Free-running 8-bit counter: 125 MHz / 256 gives about 488 kHz, far above flicker
	always @(posedge ref_clk_i) begin
		if (!rst_n_i)
			pwm_cnt_reg <= 8'h00;
		else
			pwm_cnt_reg <= pwm_cnt_reg + 8'h01; // R14
	end

	always @(posedge ref_clk_i) begin
		if (!rst_n_i)
			sync_d_reg <= 1'b0;
		else
			sync_d_reg <= blink_sync_i;
	end

	assign restart = blink_sync_i & ~sync_d_reg; // R10

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_led
			pld_led_chan u_chan (
				.ref_clk_i       (ref_clk_i),
				.rst_n_i         (rst_n_i),
				.tick_i          (tick),
				.blink_restart_i (restart),
				.pwm_cnt_i       (pwm_cnt_reg),
				.mode_i          (led_mode_i[2*g+1:2*g]),
				.duty_i          (led_duty_i[8*g+7:8*g]), // R9
				.on_time_i       (led_on_time_i[8*g+7:8*g]),
				.off_time_i      (led_off_time_i[8*g+7:8*g]),
				.lit_o           (lit[g])
			);
		end
	endgenerate

	integer p;
	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			led_c_n_o  <= 4'hf;
			led_d_n_o  <= 4'hf;
			led_c_oe_o <= 4'h0; // R2
			led_d_oe_o <= 4'h0; // R2
		end else begin
			led_c_oe_o <= 4'hf; // R3
			led_d_oe_o <= 4'hf; // R3
			for (p = 0; p < 4; p = p + 1) begin
				led_c_n_o[p] <= ~lit[2*p]; // R1
				led_d_n_o[p] <= ~lit[2*p+1]; // R1
			end
		end
	end

	// Forward the LED clock: own clock when source; otherwise chain out repeats the received one and the sync pin is released
	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			led_sync_pin_o    <= 1'b0;
			led_sync_pin_oe_o <= 1'b0;
			chain_out_pin_o   <= 1'b0;
		end else begin
			led_sync_pin_o    <= int_clk_reg;
			led_sync_pin_oe_o <= spi_mode_i & (led_clk_src_i == `PLD_SRC_INTERNAL); // R11
			if (led_clk_src_i == `PLD_SRC_INTERNAL)
				chain_out_pin_o <= int_clk_reg; // R12
			else
				chain_out_pin_o <= ext_d2_reg; // R12
		end
	end

endmodule
